// File: rtl/seip_defines.vh
`ifndef SEIP_DEFINES_VH
`define SEIP_DEFINES_VH

// core clock and self-timed programming time
`define SEIP_CLK_PERIOD_NS  20
`define SEIP_T_WP_NS        5000000
`define SEIP_T_WP_CYCLES    (`SEIP_T_WP_NS / `SEIP_CLK_PERIOD_NS)
`define SEIP_WP_CNT_W       18

// instruction lengths in serial clocks, start bit included
`define SEIP_HEAD_X8        5'h0a
`define SEIP_HEAD_X16       5'h09
`define SEIP_TOTAL_X8       5'h12
`define SEIP_TOTAL_X16      5'h19
`define SEIP_WIDTH_X8       5'h08
`define SEIP_WIDTH_X16      5'h10

// opcodes
`define SEIP_OP_EXT         2'h0
`define SEIP_OP_WRITE       2'h1
`define SEIP_OP_READ        2'h2
`define SEIP_OP_ERASE       2'h3

// extended codes in the two top address bits
`define SEIP_EXT_LOCK       2'h0
`define SEIP_EXT_FILL       2'h1
`define SEIP_EXT_CLEAR      2'h2
`define SEIP_EXT_UNLOCK     2'h3

// array geometry and erased value
`define SEIP_BYTES          128
`define SEIP_ERASED_BYTE    8'hff

`endif

// File: rtl/seip_core.v
`timescale 1ns/1ps
`include "seip_defines.vh"

// Operation
// - width select high words, low bytes
// - start bit, opcode, address, then data
// - static serial clock holds state unchanged
// - CS low enters standby unless programming
// - only read drives array data out
// - read emits dummy zero then data
// - data output changes on clock rise
// - read continues to next higher location
// - read address wraps until CS low
// - programming ignored unless write enabled
// - reset leaves device write disabled
// - write enable holds until write disable
// - single ops touch one location, all-forms all
// - busy status shown while CS high
// - self-timed cycle bounded, erase then program
// - status low busy, high when done only if CS is high as the cycle ends
// - CS fall after last bit starts programming
// - wrong clock count makes instruction invalid
// - write disable blocks all programming
module seip_core #(
  parameter WP_CYCLES = `SEIP_T_WP_CYCLES
) (
  input  wire I_CORE_CLK,
  input  wire I_RST,
  input  wire I_CHIP_SELECT,
  input  wire I_SERIAL_CLOCK_IN,
  input  wire I_DATA_IN,
  input  wire I_WORD_WIDTH_SELECT,
  output wire O_DATA_OUT,
  output wire O_DATA_OUT_OE,
  output wire O_BUSY
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_SHIFT = 6'h02;
  localparam [5:0] ST_READ  = 6'h04;
  localparam [5:0] ST_HOLD  = 6'h08;
  localparam [5:0] ST_BAD   = 6'h10;
  localparam [5:0] ST_PROG  = 6'h20;

  // programming length cut to the counter width on purpose
  localparam [31:0]               WP_FULL = WP_CYCLES;
  localparam [`SEIP_WP_CNT_W-1:0] WP_LOAD = WP_FULL[`SEIP_WP_CNT_W-1:0];

  // two-flop synchronisers and a third stage for edge finding
  reg  [3:0] sync1_reg;
  reg  [3:0] sync2_reg;
  reg        sclk_d_reg;
  reg        cs_d_reg;

  // bit 0 select, bit 1 serial clock, bit 2 data, bit 3 width select
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_reg  <= 4'h0;
      sync2_reg  <= 4'h0;
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b0;
    end else begin
      sync1_reg  <= {I_WORD_WIDTH_SELECT, I_DATA_IN, I_SERIAL_CLOCK_IN, I_CHIP_SELECT};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sync2_reg[1];
      cs_d_reg   <= sync2_reg[0];
    end
  end

  // synchronised levels; the edge stage idles low like the parked clock
  wire cs        = sync2_reg[0];
  wire sclk_lvl  = sync2_reg[1];
  wire din       = sync2_reg[2];
  wire wide_pin  = sync2_reg[3];
  wire sclk_rise = sclk_lvl & ~sclk_d_reg; // only edges advance, a parked clock holds
  wire cs_fall   = ~cs & cs_d_reg;

  reg  [5:0]                state_reg;
  reg  [4:0]                cnt_reg;
  reg  [23:0]               sr_reg;
  reg                       org16_reg;
  reg  [1:0]                op_reg;
  reg  [1:0]                ext_reg;
  reg  [6:0]                addr_reg;
  reg  [15:0]               data_reg;
  reg  [6:0]                rd_addr_reg;
  reg  [3:0]                bit_idx_reg;
  reg                       wen_reg;
  reg                       ready_reg;
  reg                       dout_reg;
  reg                       oe_reg;
  reg                       fire_reg;
  reg  [`SEIP_WP_CNT_W-1:0] wp_cnt_reg;
  reg  [7:0]                mem_reg [0:`SEIP_BYTES-1];

  // sizes for the captured organisation
  wire [4:0]  head     = org16_reg ? `SEIP_HEAD_X16 : `SEIP_HEAD_X8;
  wire [4:0]  total    = org16_reg ? `SEIP_TOTAL_X16 : `SEIP_TOTAL_X8;
  wire [3:0]  msb_idx  = org16_reg ? 4'hf : 4'h7;
  wire [23:0] sr_next  = {sr_reg[22:0], din};
  wire [4:0]  cnt_next = cnt_reg + 5'h01;

  // opcode and address fields at the end of the head
  wire [1:0] dec_op   = org16_reg ? sr_next[7:6] : sr_next[8:7];
  wire [6:0] dec_addr = org16_reg ? {1'b0, sr_next[5:0]} : sr_next[6:0];
  wire [1:0] dec_ext  = org16_reg ? sr_next[5:4] : sr_next[6:5];
  wire       dec_data = (dec_op == `SEIP_OP_WRITE) ||
                        (dec_op == `SEIP_OP_EXT && dec_ext == `SEIP_EXT_FILL);

  // classification of the held instruction
  wire      is_ext = (op_reg == `SEIP_OP_EXT);
  reg       is_all;
  reg       is_prog;
  reg       is_erase;
  reg [4:0] need;

  // programming kind and exact clock count of the held opcode
  always @* begin
    is_all   = 1'b0;
    is_prog  = 1'b0;
    is_erase = 1'b0;
    need     = head;
    case (op_reg)
      `SEIP_OP_WRITE: begin
        is_prog = 1'b1;
        need    = total;
      end
      `SEIP_OP_ERASE: begin
        is_prog  = 1'b1;
        is_erase = 1'b1;
      end
      `SEIP_OP_EXT: begin
        if (ext_reg == `SEIP_EXT_FILL) begin
          is_all  = 1'b1;
          is_prog = 1'b1;
          need    = total;
        end else if (ext_reg == `SEIP_EXT_CLEAR) begin
          is_all   = 1'b1;
          is_prog  = 1'b1;
          is_erase = 1'b1;
        end
      end
      default: begin
        need = head;                                       // read never programs
      end
    endcase
  end

  // word at the read pointer
  wire [15:0] cur_word = org16_reg ?
    {mem_reg[{rd_addr_reg[5:0], 1'b1}], mem_reg[{rd_addr_reg[5:0], 1'b0}]} :
    {8'h00, mem_reg[rd_addr_reg]};
  wire [6:0]  rd_addr_inc = org16_reg ? {1'b0, rd_addr_reg[5:0] + 6'h01} :
                                        rd_addr_reg + 7'h01;

  // instruction sequencer
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 5'h00;
      sr_reg      <= 24'h000000;
      org16_reg   <= 1'b1;
      op_reg      <= 2'h0;
      ext_reg     <= 2'h0;
      addr_reg    <= 7'h00;
      data_reg    <= 16'h0000;
      rd_addr_reg <= 7'h00;
      bit_idx_reg <= 4'h0;
      wen_reg     <= 1'b0;
      ready_reg   <= 1'b0;
      dout_reg    <= 1'b0;
      fire_reg    <= 1'b0;
      wp_cnt_reg  <= {`SEIP_WP_CNT_W{1'b0}};
    end else begin
      fire_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (!cs) begin
            ready_reg <= 1'b0;                             // status gone with CS low
          end else if (sclk_rise && din) begin             // start bit
            ready_reg <= 1'b0;
            state_reg <= ST_SHIFT;
            cnt_reg   <= 5'h01;
            sr_reg    <= 24'h000000;
            org16_reg <= wide_pin;
          end
        end
        ST_SHIFT: begin
          if (!cs) begin
            state_reg <= ST_IDLE;                          // short instruction dropped
          end else if (sclk_rise) begin
            sr_reg  <= sr_next;
            cnt_reg <= cnt_next;
            if (cnt_next == head) begin
              op_reg   <= dec_op;
              ext_reg  <= dec_ext;
              addr_reg <= dec_addr;
              if (dec_op == `SEIP_OP_READ) begin
                state_reg   <= ST_READ;
                rd_addr_reg <= dec_addr;
                bit_idx_reg <= msb_idx;
                dout_reg    <= 1'b0;                       // dummy zero
              end else if (!dec_data) begin
                state_reg <= ST_HOLD;
              end
            end else if (cnt_next == total) begin
              data_reg  <= org16_reg ? sr_next[15:0] : {8'h00, sr_next[7:0]};
              state_reg <= ST_HOLD;
            end
          end
        end
        ST_READ: begin
          if (!cs) begin
            state_reg <= ST_IDLE;                          // stream ends
          end else if (sclk_rise) begin
            dout_reg <= cur_word[bit_idx_reg];
            if (bit_idx_reg == 4'h0) begin
              bit_idx_reg <= msb_idx;
              rd_addr_reg <= rd_addr_inc;                  // next location
            end else begin
              bit_idx_reg <= bit_idx_reg - 4'h1;
            end
          end
        end
        ST_HOLD: begin
          if (cs_fall) begin
            state_reg <= ST_IDLE;                          // standby
            if (cnt_reg == need) begin                     // exact count
              if (is_ext && ext_reg == `SEIP_EXT_UNLOCK) begin
                wen_reg <= 1'b1;
              end else if (is_ext && ext_reg == `SEIP_EXT_LOCK) begin
                wen_reg <= 1'b0;
              end else if (is_prog && wen_reg) begin
                state_reg  <= ST_PROG;
                wp_cnt_reg <= WP_LOAD;
                dout_reg   <= 1'b0;
              end
            end
          end else if (sclk_rise) begin
            state_reg <= ST_BAD;                           // extra clock
          end
        end
        ST_BAD: begin
          if (!cs) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PROG: begin
          if (wp_cnt_reg <= {{(`SEIP_WP_CNT_W-1){1'b0}}, 1'b1}) begin
            fire_reg  <= 1'b1;                             // bounded cycle
            state_reg <= ST_IDLE;
            ready_reg <= cs;
            dout_reg  <= 1'b1;
          end else begin
            wp_cnt_reg <= wp_cnt_reg - {{(`SEIP_WP_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // output enable: read stream, busy poll, or ready poll, all gated by select
  reg oe_next;

  always @* begin
    oe_next = 1'b0;
    case (state_reg)
      ST_READ: begin
        oe_next = cs;
      end
      ST_PROG: begin
        oe_next = cs;                                      // busy poll
      end
      ST_IDLE: begin
        oe_next = cs & ready_reg;                          // ready poll
      end
      default: begin
        oe_next = 1'b0;
      end
    endcase
  end

  // registered so the pin enable never glitches
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // array: one generate entry per byte, updated at the end of the cycle
  genvar gi;
  generate
    for (gi = 0; gi < `SEIP_BYTES; gi = gi + 1) begin : g_byte
      localparam [31:0] IDX_FULL = gi;
      wire [6:0] idx = IDX_FULL[6:0];
      wire       hit = is_all ||
                       (org16_reg ? (addr_reg[5:0] == idx[6:1]) : (addr_reg == idx));
      wire [7:0] val = is_erase ? `SEIP_ERASED_BYTE :                   // erase then program
                       ((org16_reg && idx[0]) ? data_reg[15:8] : data_reg[7:0]);
      always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
          mem_reg[gi] <= `SEIP_ERASED_BYTE;
        end else if (fire_reg && hit) begin
          mem_reg[gi] <= val;
        end
      end
    end
  endgenerate

  assign O_DATA_OUT    = dout_reg;
  assign O_DATA_OUT_OE = oe_reg;
  assign O_BUSY        = (state_reg == ST_PROG);

endmodule // seip_core

// File: tb/seip_chk_sva.sv
`timescale 1ns/1ps
module seip_chk #(
  parameter WP_CYCLES = 200
) (
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire I_CHIP_SELECT,
  input wire I_SERIAL_CLOCK_IN,
  input wire I_DATA_IN,
  input wire I_WORD_WIDTH_SELECT,
  input wire O_DATA_OUT,
  input wire O_DATA_OUT_OE,
  input wire O_BUSY
);
  reg [31:0] busy_cnt_reg;
  // length of the running programming cycle
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= O_BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // pin behaviour around chip select, serial clock and status
  property p_oe_off; !I_CHIP_SELECT [*6] |-> !O_DATA_OUT_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe with cs low");
  property p_oe_rise; $rose(O_DATA_OUT_OE) |-> $past(I_CHIP_SELECT, 2); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("oe rose w/o cs");
  property p_busy_max; O_BUSY |-> busy_cnt_reg <= WP_CYCLES + 3; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_min; $fell(O_BUSY) |-> busy_cnt_reg + 3 >= WP_CYCLES; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_cs; $rose(O_BUSY) |-> !I_CHIP_SELECT && !$past(I_CHIP_SELECT); endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("busy w/o cs fall");
  property p_busy_low;
    O_BUSY && O_DATA_OUT_OE && busy_cnt_reg + 4 < WP_CYCLES |-> !O_DATA_OUT;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy not low");
  property p_ready;
    $fell(O_BUSY) && I_CHIP_SELECT && $past(I_CHIP_SELECT, 8)
      |-> ##[0:4] (O_DATA_OUT && O_DATA_OUT_OE);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_on_rise;
    $changed(O_DATA_OUT) && O_DATA_OUT_OE && $past(O_DATA_OUT_OE) && !$past(O_BUSY)
      && !$past(O_BUSY, 2) && !$past(O_BUSY, 3) |-> $past(I_SERIAL_CLOCK_IN, 2);
  endproperty
  a_on_rise: assert property (p_on_rise) else $error("dout off rise");
endmodule // seip_chk

bind seip_core seip_chk #(.WP_CYCLES(WP_CYCLES)) chk_u (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CHIP_SELECT(I_CHIP_SELECT),
  .I_SERIAL_CLOCK_IN(I_SERIAL_CLOCK_IN), .I_DATA_IN(I_DATA_IN),
  .I_WORD_WIDTH_SELECT(I_WORD_WIDTH_SELECT), .O_DATA_OUT(O_DATA_OUT),
  .O_DATA_OUT_OE(O_DATA_OUT_OE), .O_BUSY(O_BUSY));

// File: tb/seip_host.sv
`timescale 1ns/1ps
module seip_host (
  input  wire  i_clk,
  input  wire  i_dout,
  input  wire  i_oe,
  output logic o_cs,
  output logic o_sclk,
  output logic o_di
);
  // idle: deselected, serial clock parked low
  initial begin
    o_cs = 1'b0;
    o_sclk = 1'b0;
    o_di = 1'b0;
  end
  // one frame, msb first, 8 core cycles a bit; dout taken before each rise
  task xfer(input logic [63:0] v, input int n, output logic [63:0] rx);
    rx = 64'h0;
    @(negedge i_clk) o_cs = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      o_di = v[i];
      repeat (4) @(negedge i_clk);
      rx = {rx[62:0], i_dout};
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_cs = 1'b0;
    o_di = ~o_di;
    repeat (8) @(negedge i_clk);
  endtask
  // select and wait for busy low then ready high, bounded
  task poll(output logic ok);
    ok = 1'b0;
    @(negedge i_clk) o_cs = 1'b1;
    repeat (8) @(negedge i_clk);
    if (i_oe === 1'b1 && i_dout === 1'b0) begin
      for (int i = 0; i < 400 && !ok; i++) begin
        @(negedge i_clk);
        ok = (i_oe === 1'b1 && i_dout === 1'b1);
      end
    end
    @(negedge i_clk) o_cs = 1'b0;
    repeat (8) @(negedge i_clk);
  endtask
endmodule // seip_host

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        width_sel = 1'b1;
  logic        cs, sclk, di, dout, oe, busy;
  logic [63:0] rx;
  logic [6:0]  a;
  logic [15:0] d;
  logic [7:0]  mem [128];
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 73122;

  seip_host host_u (.i_clk(clk), .i_dout(dout), .i_oe(oe), .o_cs(cs), .o_sclk(sclk),
    .o_di(di));
  seip_core #(.WP_CYCLES(200)) dut_u (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CHIP_SELECT(cs), .I_SERIAL_CLOCK_IN(sclk),
    .I_DATA_IN(di), .I_WORD_WIDTH_SELECT(width_sel), .O_DATA_OUT(dout), .O_DATA_OUT_OE(oe),
    .O_BUSY(busy));
  // 50 MHz core clock and a run limit
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    final_report;
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // reference array update, word w is bytes 2w and 2w+1
  task put(input logic w, input int x, input logic [15:0] v);
    if (w)
      {mem[2*x+1], mem[2*x]} = v;
    else
      mem[x] = v[7:0];
  endtask
  // header, then dn trailing bits of d
  task cmd(input logic w, input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
           input int dn);
    logic [63:0] v;
    @(negedge clk) width_sel = w;
    v = w ? {1'b1, op, a[5:0]} : {1'b1, op, a};
    host_u.xfer((v << dn) | d, (w ? 9 : 10) + dn, rx);
  endtask
  // sequential read of nw units compared with the reference
  task rd(input logic w, input logic [6:0] a, input int nw);
    int dw;
    int x;
    dw = w ? 16 : 8;
    cmd(w, 2'h2, a, 16'h0, nw * dw + 1);
    chk(rx[nw*dw], 1'b0);
    for (int k = 0; k < nw; k++) begin
      x = (a + k) % (w ? 64 : 128);
      chk((rx >> (dw * (nw - 1 - k))) & (w ? 64'hffff : 64'hff),
          w ? {mem[2*x+1], mem[2*x]} : {8'h0, mem[x]});
    end
  endtask
  // programming instruction, then status polling
  task prog(input logic w, input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
            input int dn, input logic en);
    logic ok;
    cmd(w, op, a, d, dn);
    chk(busy, en);
    host_u.poll(ok);
    chk(ok, en);
    chk(busy, 1'b0);
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'hff;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    prog(1, 2'h1, 7'h05, 16'h1234, 16, 1'b0);
    rd(1, 7'h05, 1);
    $display("test locked done");
    cmd(1, 2'h0, 7'h30, 16'h0, 0);
    for (int w = 0; w < 2; w++) begin
      a = 7'($random(seed)) & (w ? 7'h3f : 7'h7f);
      d = 16'($random(seed)) & (w ? 16'hffff : 16'h00ff);
      prog(1'(w), 2'h1, a, d, w ? 16 : 8, 1'b1);
      put(1'(w), a, d);
      rd(1'(w), a, 2);
      prog(1'(w), 2'h3, a, 16'h0, 0, 1'b1);
      put(1'(w), a, 16'hffff);
      rd(1'(w), a, 2);
      $display("test single org %0d done", w);
    end
    d = 16'($random(seed));
    prog(1, 2'h0, 7'h10, d, 16, 1'b1);
    for (int x = 0; x < 64; x++)
      put(1, x, d);
    rd(1, 7'h3f, 2);
    prog(0, 2'h0, 7'h40, 16'h0, 0, 1'b1);
    for (int x = 0; x < 128; x++)
      put(0, x, 16'hff);
    rd(0, 7'h7f, 2);
    $display("test whole array done");
    prog(0, 2'h1, 7'h11, 16'h5a, 9, 1'b0);
    rd(0, 7'h11, 1);
    cmd(1, 2'h0, 7'h00, 16'h0, 0);
    prog(1, 2'h1, 7'h11, 16'h1234, 16, 1'b0);
    rd(1, 7'h11, 1);
    $display("test lock and count done");
    final_report;
  end
endmodule // testbench
